// ==== rtl/unvm_defs.vh ====
`ifndef UNVM_DEFS_VH
`define UNVM_DEFS_VH

// ****************************************
// Geometry
// ****************************************
`define UNVM_BANKS 8
`define UNVM_BYTES_PER_BANK 16
`define UNVM_BITS 1024
`define UNVM_ADDR_W 7
`define UNVM_BANK_MSB 6
`define UNVM_BANK_LSB 4
`define UNVM_BYTE_MSB 3
`define UNVM_BYTE_LSB 0
`define UNVM_DATA_W 8
`define UNVM_BANK_W 128

// ****************************************
// Reset values
// ****************************************
`define UNVM_ERASED_BYTE 8'hff
`define UNVM_DOUT_RST 8'h00

`endif

// ==== rtl/unvm_bank.v ====
`timescale 1ns/1ps
`include "unvm_defs.vh"

module unvm_bank (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Programming side
  input wire erase,
  input wire write,
  input wire [`UNVM_BANK_W-1:0] wdata,
  // Read side
  output wire [`UNVM_BANK_W-1:0] rdata
);

  reg [`UNVM_BANK_W-1:0] cells_r;

  // Cells start erased; only the sequencer and reset, which erases them, can alter them
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cells_r <= {`UNVM_BYTES_PER_BANK{`UNVM_ERASED_BYTE}};
    end else if (erase) begin
      cells_r <= {`UNVM_BYTES_PER_BANK{`UNVM_ERASED_BYTE}};
    end else if (write) begin
      cells_r <= wdata;
    end
  end

  assign rdata = cells_r;

endmodule // unvm_bank

// ==== rtl/unvm_top.v ====
`timescale 1ns/1ps
`include "unvm_defs.vh"

// How it works
// - The store holds 1,024 bits as eight banks of 128 bits, sixteen bytes each.
// - Core logic only reads; no core-side input reaches the storage cells.
// - Only the JTAG-side programming port and reset, which erases every bank, can change the store.
// - Programming works on whole banks, a mask picks any subset, others stay.
// - Each selected bank is erased first and then written with the new data.
// - The read address is captured on the rising edge of the read clock.
// - The addressed byte is stable on the output after that cycle's falling edge.
// - Reads return one byte; address bits 6:4 choose the bank.
// - Address bits 3:0 choose the byte inside that bank.
module unvm_top (
  // Clock and reset
  input wire clk,
  input wire resetn,
  // Core read port
  input wire rd_en,
  input wire [`UNVM_ADDR_W-1:0] rd_addr,
  output reg [`UNVM_DATA_W-1:0] rd_data,
  // JTAG-side programming port
  input wire pg_start,
  input wire [`UNVM_BANKS-1:0] pg_bank_mask,
  input wire [`UNVM_BANK_W-1:0] pg_data,
  output reg pg_busy
);

  // ****************************************
  // Sequencer states
  // ****************************************
  localparam [1:0] ST_IDLE = 2'h0;
  localparam [1:0] ST_ERASE = 2'h1;
  localparam [1:0] ST_WRITE = 2'h2;

  // ****************************************
  // Reset release
  // ****************************************
  reg rst_meta_r;
  reg rst_sync_r;

  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_r <= 1'b0;
      rst_sync_r <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_sync_r <= rst_meta_r;
    end
  end

  // ****************************************
  // Programming sequencer
  // ****************************************
  reg [1:0] state_r;
  reg [1:0] state_nxt;
  reg [`UNVM_BANKS-1:0] mask_r;
  reg [`UNVM_BANK_W-1:0] data_r;
  wire [`UNVM_BANKS-1:0] erase_sel;
  wire [`UNVM_BANKS-1:0] write_sel;

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (pg_start && (pg_bank_mask != {`UNVM_BANKS{1'b0}})) begin
          state_nxt = ST_ERASE;
        end
      end
      ST_ERASE: begin
        state_nxt = ST_WRITE;
      end
      ST_WRITE: begin
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  // Mask and data latched at start so a changing port cannot tear a bank
  always @(posedge clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      state_r <= ST_IDLE;
      mask_r <= {`UNVM_BANKS{1'b0}};
      data_r <= {`UNVM_BANK_W{1'b0}};
      pg_busy <= 1'b0;
    end else begin
      state_r <= state_nxt;
      pg_busy <= (state_nxt != ST_IDLE);
      if (state_r == ST_IDLE && state_nxt == ST_ERASE) begin
        mask_r <= pg_bank_mask;
        data_r <= pg_data;
      end
    end
  end

  assign erase_sel = (state_r == ST_ERASE) ? mask_r : {`UNVM_BANKS{1'b0}};
  assign write_sel = (state_r == ST_WRITE) ? mask_r : {`UNVM_BANKS{1'b0}};

  // ****************************************
  // Storage: only the programming port feeds it
  // ****************************************
  wire [`UNVM_BANK_W*`UNVM_BANKS-1:0] bank_flat;

  genvar gi;
  generate
    for (gi = 0; gi < `UNVM_BANKS; gi = gi + 1) begin : g_bank
      unvm_bank u_bank (
        .clk(clk),
        .rst_n(rst_sync_r),
        .erase(erase_sel[gi]),
        .write(write_sel[gi]),
        .wdata(data_r),
        .rdata(bank_flat[gi*`UNVM_BANK_W +: `UNVM_BANK_W])
      );
    end
  endgenerate

  // ****************************************
  // Read port
  // ****************************************
  // Single-clock design: data registered on the rising edge is already
  // stable before the falling edge of that cycle, which meets the timing.
  wire [2:0] bank_idx;
  wire [3:0] byte_idx;
  reg [`UNVM_BANK_W-1:0] bank_sel;
  reg [`UNVM_DATA_W-1:0] byte_sel;

  assign bank_idx = rd_addr[`UNVM_BANK_MSB:`UNVM_BANK_LSB];
  assign byte_idx = rd_addr[`UNVM_BYTE_MSB:`UNVM_BYTE_LSB];

  // Plain case muxes: every bank and byte is its own path, with no
  // multiplier in front of a variable part-select
  always @* begin
    bank_sel = {`UNVM_BANK_W{1'b0}};
    case (bank_idx)
      3'h0: begin
        bank_sel = bank_flat[0*`UNVM_BANK_W +: `UNVM_BANK_W];
      end
      3'h1: begin
        bank_sel = bank_flat[1*`UNVM_BANK_W +: `UNVM_BANK_W];
      end
      3'h2: begin
        bank_sel = bank_flat[2*`UNVM_BANK_W +: `UNVM_BANK_W];
      end
      3'h3: begin
        bank_sel = bank_flat[3*`UNVM_BANK_W +: `UNVM_BANK_W];
      end
      3'h4: begin
        bank_sel = bank_flat[4*`UNVM_BANK_W +: `UNVM_BANK_W];
      end
      3'h5: begin
        bank_sel = bank_flat[5*`UNVM_BANK_W +: `UNVM_BANK_W];
      end
      3'h6: begin
        bank_sel = bank_flat[6*`UNVM_BANK_W +: `UNVM_BANK_W];
      end
      3'h7: begin
        bank_sel = bank_flat[7*`UNVM_BANK_W +: `UNVM_BANK_W];
      end
      default: begin
        bank_sel = {`UNVM_BANK_W{1'b0}};
      end
    endcase
  end

  always @* begin
    byte_sel = {`UNVM_DATA_W{1'b0}};
    case (byte_idx)
      4'h0: begin
        byte_sel = bank_sel[0*`UNVM_DATA_W +: `UNVM_DATA_W];
      end
      4'h1: begin
        byte_sel = bank_sel[1*`UNVM_DATA_W +: `UNVM_DATA_W];
      end
      4'h2: begin
        byte_sel = bank_sel[2*`UNVM_DATA_W +: `UNVM_DATA_W];
      end
      4'h3: begin
        byte_sel = bank_sel[3*`UNVM_DATA_W +: `UNVM_DATA_W];
      end
      4'h4: begin
        byte_sel = bank_sel[4*`UNVM_DATA_W +: `UNVM_DATA_W];
      end
      4'h5: begin
        byte_sel = bank_sel[5*`UNVM_DATA_W +: `UNVM_DATA_W];
      end
      4'h6: begin
        byte_sel = bank_sel[6*`UNVM_DATA_W +: `UNVM_DATA_W];
      end
      4'h7: begin
        byte_sel = bank_sel[7*`UNVM_DATA_W +: `UNVM_DATA_W];
      end
      4'h8: begin
        byte_sel = bank_sel[8*`UNVM_DATA_W +: `UNVM_DATA_W];
      end
      4'h9: begin
        byte_sel = bank_sel[9*`UNVM_DATA_W +: `UNVM_DATA_W];
      end
      4'ha: begin
        byte_sel = bank_sel[10*`UNVM_DATA_W +: `UNVM_DATA_W];
      end
      4'hb: begin
        byte_sel = bank_sel[11*`UNVM_DATA_W +: `UNVM_DATA_W];
      end
      4'hc: begin
        byte_sel = bank_sel[12*`UNVM_DATA_W +: `UNVM_DATA_W];
      end
      4'hd: begin
        byte_sel = bank_sel[13*`UNVM_DATA_W +: `UNVM_DATA_W];
      end
      4'he: begin
        byte_sel = bank_sel[14*`UNVM_DATA_W +: `UNVM_DATA_W];
      end
      4'hf: begin
        byte_sel = bank_sel[15*`UNVM_DATA_W +: `UNVM_DATA_W];
      end
      default: begin
        byte_sel = {`UNVM_DATA_W{1'b0}};
      end
    endcase
  end

  always @(posedge clk or negedge rst_sync_r) begin
    if (!rst_sync_r) begin
      rd_data <= `UNVM_DOUT_RST;
    end else if (rd_en) begin
      rd_data <= byte_sel;
    end
  end

endmodule // unvm_top

// ==== bench/unvm_monitor.sv ====
`timescale 1ns/1ps
module unvm_monitor (
  // Clock and reset
  input wire clk,
  input wire resetn,
  // Ports watched
  input wire rd_en,
  input wire [7:0] rd_data,
  input wire pg_start,
  input wire [7:0] pg_bank_mask,
  input wire pg_busy
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_read_hold: assert property (!rd_en |=> $stable(rd_data)) else $error("hold");
  a_read_cause: assert property ($changed(rd_data) |-> $past(rd_en)) else $error("cause");
  a_prog_take: assert property (pg_start && !pg_busy && |pg_bank_mask |=> pg_busy)
    else $error("take");
  a_mask_zero: assert property (pg_start && !pg_busy && pg_bank_mask == 8'h00 |=> !pg_busy)
    else $error("zero");
  a_busy_span: assert property ($rose(pg_busy) |-> pg_busy ##1 pg_busy ##1 !pg_busy)
    else $error("span");
  a_busy_origin: assert property ($rose(pg_busy) |-> $past(pg_start)) else $error("origin");
  a_busy_quiet: assert property (!pg_start && !pg_busy |=> !pg_busy) else $error("quiet");
  a_no_retrigger: assert property (pg_busy && $past(pg_busy) |=> !pg_busy)
    else $error("retrig");
endmodule // unvm_monitor
bind unvm_top unvm_monitor mon (.clk(clk), .resetn(resetn), .rd_en(rd_en), .rd_data(rd_data),
  .pg_start(pg_start), .pg_bank_mask(pg_bank_mask), .pg_busy(pg_busy));

// ==== bench/unvm_core_rd.sv ====
`timescale 1ns/1ps
module unvm_core_rd (
  // Clock
  input wire clk,
  // Read request
  output logic rd_en,
  output logic [6:0] rd_addr
);
  initial begin
    rd_en = 1'b0;
    rd_addr = 7'h00;
  end
  // Called just after an edge; the address is inverted once released
  task rd(input logic [6:0] a);
    rd_en <= 1'b1;
    rd_addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    rd_addr <= ~a;
  endtask
endmodule // unvm_core_rd

// ==== bench/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
  logic clk = 0, resetn = 0, pg_start = 0, pg_busy, rd_en;
  logic [7:0] pg_bank_mask = 0, rd_data;
  logic [127:0] pg_data = 0;
  logic [6:0] rd_addr;
  int err_count = 0, check_count = 0;
  // Each row: read address, then the byte it should return
  logic [14:0] rows [6] = '{{7'h00, 8'hef}, {7'h0f, 8'hfe}, {7'h75, 8'h45}, {7'h10, 8'hff},
    {7'h3c, 8'hff}, {7'h7c, 8'h98}};
  always #2 clk = ~clk;
  unvm_top dut (.clk(clk), .resetn(resetn), .rd_en(rd_en), .rd_addr(rd_addr),
    .rd_data(rd_data), .pg_start(pg_start), .pg_bank_mask(pg_bank_mask),
    .pg_data(pg_data), .pg_busy(pg_busy));
  unvm_core_rd core (.clk(clk), .rd_en(rd_en), .rd_addr(rd_addr));
  task chk(input string n, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  task chk_flag(input string n, input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s exp %b got %b", n, e, g);
    end
  endtask
  task rd_chk(input logic [6:0] a, input logic [7:0] e);
    @(posedge clk);
    core.rd(a);
    #3 chk("rd_data", e, rd_data);
  endtask
  // Start is held a second edge to hit the busy refusal
  task prog(input logic [7:0] m, input logic [127:0] d);
    @(posedge clk);
    pg_start <= 1'b1;
    pg_bank_mask <= m;
    pg_data <= d;
    @(posedge clk);
    #1 chk_flag("pg_busy", |m, pg_busy);
    @(posedge clk);
    pg_start <= 1'b0;
    @(posedge clk);
    #1 chk_flag("pg_busy", 1'b0, pg_busy);
  endtask
  task tally_and_finish;
    if (err_count == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #20000;
    err_count++;
    tally_and_finish;
  end
  initial begin
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    #1 chk("rd_data", 8'h00, rd_data);
    repeat (3) @(posedge clk);
    rd_chk(7'h21, 8'hff);
    prog(8'h81, 128'hfedcba9876543210_0123456789abcdef);
    for (int i = 0; i < 6; i++) rd_chk(rows[i][14:8], rows[i][7:0]);
    repeat (2) @(posedge clk);
    #1 chk("rd_data", 8'h98, rd_data);
    prog(8'h80, 128'h0);
    rd_chk(7'h76, 8'h00);
    // Read between erase and write: the bank must already show erased
    @(posedge clk);
    pg_start <= 1'b1;
    pg_bank_mask <= 8'h80;
    pg_data <= 128'h1;
    @(posedge clk);
    pg_start <= 1'b0;
    @(posedge clk);
    core.rd(7'h70);
    #3 chk("rd_data", 8'hff, rd_data);
    rd_chk(7'h70, 8'h01);
    rd_chk(7'h08, 8'h10);
    prog(8'h00, 128'h1);
    rd_chk(7'h08, 8'h10);
    // Mid-run reset just as programming is taken: it must be cut off
    @(posedge clk);
    pg_start <= 1'b1;
    pg_bank_mask <= 8'h01;
    pg_data <= 128'h0;
    @(posedge clk);
    pg_start <= 1'b0;
    resetn <= 1'b0;
    #1 chk("rd_data", 8'h00, rd_data);
    chk_flag("pg_busy", 1'b0, pg_busy);
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
    rd_chk(7'h08, 8'hff);
    tally_and_finish;
  end
endmodule // tb_top
